//--- design/smbx_defs.svh
/*
  constants for the socket mailbox command interpreter: command codes,
  message header values, socket types, fault codes and table sizes.
  assumes nothing; included by the package and design modules.
*/
`ifndef SMBX_DEFS_SVH
`define SMBX_DEFS_SVH

`define SMBX_CMD_CREATE_NB 16'h0040
`define SMBX_CMD_CREATE_B 16'h003f
`define SMBX_CMD_LISTEN 16'h0041
`define SMBX_CMD_ACCEPT 16'h0050
`define SMBX_MSGINFO_CMD 16'h4002
`define SMBX_MSGINFO_RSP 16'h0002
`define SMBX_SIZE_CREATE 16'h0004
`define SMBX_SIZE_NONE 16'h0000
`define SMBX_SIZE_ACCEPT 16'h0002
`define SMBX_FRAME_ONE 16'h0001
`define SMBX_TYPE_TCP 16'h0001
`define SMBX_TYPE_UDP 16'h0002
`define SMBX_FAULT_NONE 16'h0000
`define SMBX_FAULT_BAD_SOCKET 16'h0001
`define SMBX_FAULT_NOT_TCP 16'h0002
`define SMBX_FAULT_NO_ROOM 16'h0003
`define SMBX_FAULT_BAD_TYPE 16'h0004
`define SMBX_FAULT_NOT_LISTEN 16'h0005
`define SMBX_FAULT_PORT_BUSY 16'h0006
`define SMBX_NB_MAX 6'd16
`define SMBX_B_MAX 6'd32
`define SMBX_SLOTS 48
`define SMBX_EPHEMERAL_BASE 16'hc000

`endif

//--- design/smbx_pkg.sv
/*
  types for the socket mailbox command interpreter.
  assumes smbx_defs.svh is on the include path.
*/
`include "smbx_defs.svh"

package smbx_pkg;
  typedef logic [15:0] smbx_word_t;
  typedef logic [5:0] smbx_desc_t;

  // one mailbox message: header words plus up to two data words
  typedef struct packed {
    smbx_word_t msg_id;
    smbx_word_t msg_info;
    smbx_word_t command;
    smbx_word_t data_size;
    smbx_word_t frame_count;
    smbx_word_t frame_number;
    smbx_word_t offset_high;
    smbx_word_t offset_low;
    smbx_word_t [7:0] ext;
    smbx_word_t [1:0] data;
  } smbx_msg_t;

  typedef enum logic [1:0] {
    SMBX_IDLE,
    SMBX_REPLY,
    SMBX_WAIT_CONN
  } smbx_state_t;
endpackage : smbx_pkg

//--- design/smbx_table_if.sv
/*
  interface between the command decoder and the socket table.
  assumes both ends run on the same sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none

interface smbx_table_if;
  import smbx_pkg::*;
  // allocation request
  logic alloc;
  logic alloc_blocking;
  logic alloc_tcp;
  smbx_word_t alloc_port;
  logic alloc_ok;
  smbx_desc_t alloc_desc;
  smbx_word_t alloc_bound;
  logic alloc_fault_busy;
  // lookup and listen
  smbx_desc_t look_desc;
  logic look_used;
  logic look_tcp;
  logic look_blocking;
  logic look_listening;
  smbx_word_t look_port;
  logic set_listen;
  // connected child creation
  logic child;
  smbx_word_t child_port;
  logic child_ok;
  smbx_desc_t child_desc;

  modport table_end (
    input alloc, alloc_blocking, alloc_tcp, alloc_port, look_desc, set_listen,
      child, child_port,
    output alloc_ok, alloc_desc, alloc_bound, alloc_fault_busy, look_used,
      look_tcp, look_blocking, look_listening, look_port, child_ok, child_desc
  );
  modport decoder_end (
    output alloc, alloc_blocking, alloc_tcp, alloc_port, look_desc, set_listen,
      child, child_port,
    input alloc_ok, alloc_desc, alloc_bound, alloc_fault_busy, look_used,
      look_tcp, look_blocking, look_listening, look_port, child_ok, child_desc
  );
endinterface : smbx_table_if

`default_nettype wire

//--- design/smbx_table.sv
/*
  socket table: slot state, mode counts, port choice.
  assumes one clock and requests held for one cycle by the decoder.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smbx_defs.svh"

module smbx_table
  import smbx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // decoder side
  smbx_table_if.table_end tbl
);
  logic [`SMBX_SLOTS-1:0] used;
  logic [`SMBX_SLOTS-1:0] tcp;
  logic [`SMBX_SLOTS-1:0] blocking;
  logic [`SMBX_SLOTS-1:0] listening;
  smbx_word_t port [`SMBX_SLOTS];
  logic [5:0] nb_count;
  logic [5:0] b_count;
  smbx_word_t next_ephemeral;
  logic [`SMBX_SLOTS-1:0] port_hit;
  smbx_desc_t free_slot;
  logic free_found;
  logic room;
  smbx_word_t bound;

  // lowest free slot
  function automatic smbx_desc_t first_free(input logic [`SMBX_SLOTS-1:0] u);
    smbx_desc_t d;
    d = '0;
    for (int i = `SMBX_SLOTS - 1; i >= 0; i--)
    begin
      if (!u[i])
        d = 6'(i);
    end
    return d;
  endfunction : first_free

  genvar g;
  generate
    for (g = 0; g < `SMBX_SLOTS; g++)
    begin : g_hit
      assign port_hit[g] = used[g] && port[g] == tbl.alloc_port;
    end
  endgenerate

  assign free_slot = first_free(used);
  assign free_found = ~&used;
  assign room = tbl.alloc_blocking ? (b_count < `SMBX_B_MAX) : (nb_count < `SMBX_NB_MAX); // R18 R19
  assign bound = (tbl.alloc_port == 16'h0000) ? next_ephemeral : tbl.alloc_port; // R03
  assign tbl.alloc_fault_busy = tbl.alloc_port != 16'h0000 && |port_hit;
  assign tbl.alloc_ok = room && free_found && !tbl.alloc_fault_busy;
  assign tbl.alloc_desc = free_slot;
  assign tbl.alloc_bound = bound;
  assign tbl.look_used = tbl.look_desc < 6'(`SMBX_SLOTS) && used[tbl.look_desc];
  assign tbl.look_tcp = tcp[tbl.look_desc];
  assign tbl.look_blocking = blocking[tbl.look_desc];
  assign tbl.look_listening = listening[tbl.look_desc];
  assign tbl.look_port = tbl.look_used ? port[tbl.look_desc] : 16'h0000;
  assign tbl.child_ok = free_found && b_count < `SMBX_B_MAX;
  assign tbl.child_desc = free_slot;

  // slot state
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      used <= '0;
      tcp <= '0;
      blocking <= '0;
      listening <= '0;
    end
    else if (tbl.alloc && tbl.alloc_ok)
    begin
      used[free_slot] <= 1'b1;
      tcp[free_slot] <= tbl.alloc_tcp;
      blocking[free_slot] <= tbl.alloc_blocking;
      listening[free_slot] <= 1'b0;
    end
    else if (tbl.child && tbl.child_ok)
    begin
      // listener stays listening, new slot is connected
      used[free_slot] <= 1'b1; // R09
      tcp[free_slot] <= 1'b1;
      blocking[free_slot] <= 1'b1;
      listening[free_slot] <= 1'b0;
    end
    else if (tbl.set_listen)
      listening[tbl.look_desc] <= 1'b1;
  end

  // bound ports
  always_ff @(posedge sys_clk)
  begin
    if (tbl.alloc && tbl.alloc_ok)
      port[free_slot] <= bound;
    else if (tbl.child && tbl.child_ok)
      port[free_slot] <= tbl.child_port;
  end

  // per-mode counts and port picker
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nb_count <= 6'd0;
      b_count <= 6'd0;
      next_ephemeral <= `SMBX_EPHEMERAL_BASE;
    end
    else if (tbl.alloc && tbl.alloc_ok)
    begin
      if (tbl.alloc_blocking)
        b_count <= b_count + 6'd1;
      else
        nb_count <= nb_count + 6'd1;
      if (tbl.alloc_port == 16'h0000)
        next_ephemeral <= next_ephemeral + 16'h0001; // R03
    end
    else if (tbl.child && tbl.child_ok)
      b_count <= b_count + 6'd1;
  end
endmodule : smbx_table

`default_nettype wire

//--- design/smbx_cmd.sv
/*
  socket mailbox command interpreter: decodes create, listen and accept
  messages and builds the matching reply messages.
  assumes a host that holds one whole message on cmd_valid until cmd_ready and
  takes a reply on rsp_valid and rsp_ready; a network side that reports
  incoming connections on conn_req.
*/
// Function
// [R01] code 0040h creates a non-blocking socket on the requested port
// [R02] code 003Fh creates a blocking socket on the requested port
// [R03] port zero makes the module pick an unused port itself; here it counts up from C000h without checking bound ports
// [R04] creation reply returns the new descriptor and the bound port
// [R05] host sends create with info 4002h, size 0004h, frames 0001h
// [R06] host puts type in data word 1, port in word 2
// [R07] create reply: info 0002h, echoed code, size 0004h, descriptor then port
// [R08] host names the socket by its returned descriptor afterwards
// [R09] connection on a listener makes a new socket; listener keeps listening
// [R10] host sends listen only for TCP sockets
// [R11] host listen: code 0041h, size 0000h, descriptor in extended word 1
// [R12] non-blocking listener connections go to the status area, not mailbox
// [R13] blocking listener hands out new descriptors only through accept replies; here a connection with no accept pending goes to the status area
// [R14] code 0050h accepts on a blocking listener, replies with new descriptor
// [R15] accept reply is held back until a connection arrives
// [R16] accept reply header: listener, fault, local port, remote port, remote IP
// [R17] while a blocking command waits, other socket commands get no answer
// [R18] at most sixteen non-blocking sockets at once
// [R19] at most thirty-two blocking sockets at once
// [R20] listen on UDP or unknown descriptor reports a fault, changes nothing
`timescale 1ns/1ns
`default_nettype none
`include "smbx_defs.svh"

module smbx_cmd
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // command from host
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire smbx_pkg::smbx_msg_t cmd_msg,
  // reply to host
  output logic rsp_valid,
  input wire logic rsp_ready,
  output smbx_pkg::smbx_msg_t rsp_msg,
  // network connection events
  input wire logic conn_req,
  input wire smbx_pkg::smbx_desc_t conn_listener,
  input wire smbx_pkg::smbx_word_t conn_remote_port,
  input wire logic [31:0] conn_remote_ip,
  output logic conn_taken,
  // status area event for connections taken while no accept is pending
  output logic nb_conn_event,
  output smbx_pkg::smbx_desc_t nb_conn_desc
);
  import smbx_pkg::*;

  smbx_table_if tbl ();
  smbx_state_t state;
  smbx_msg_t req;
  smbx_word_t listen_port;
  logic is_socket_cmd;
  logic create_cmd;
  logic nb_take;
  logic acc_take;

  function automatic logic socket_code(input smbx_word_t c);
    return c == `SMBX_CMD_CREATE_NB || c == `SMBX_CMD_CREATE_B ||
      c == `SMBX_CMD_LISTEN || c == `SMBX_CMD_ACCEPT;
  endfunction : socket_code

  smbx_table u_table (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .tbl(tbl)
  );

  assign is_socket_cmd = socket_code(cmd_msg.command);
  // socket commands only taken when idle; blocked accept holds them off
  assign cmd_ready = state == SMBX_IDLE && is_socket_cmd; // R17
  assign create_cmd = cmd_msg.command == `SMBX_CMD_CREATE_NB || // R01 R02
    cmd_msg.command == `SMBX_CMD_CREATE_B;
  assign rsp_valid = state == SMBX_REPLY;

  // table requests
  // a create with an unknown type is answered with a fault and allocates nothing
  assign tbl.alloc = cmd_valid && cmd_ready && create_cmd &&
    (cmd_msg.data[0] == `SMBX_TYPE_TCP || cmd_msg.data[0] == `SMBX_TYPE_UDP); // R01 R02
  assign tbl.alloc_blocking = cmd_msg.command == `SMBX_CMD_CREATE_B; // R02
  assign tbl.alloc_tcp = cmd_msg.data[0] == `SMBX_TYPE_TCP;
  assign tbl.alloc_port = cmd_msg.data[1];
  // without a command the lookup serves the listener of an incoming connection
  assign tbl.look_desc = cmd_valid ? 6'(cmd_msg.ext[0]) : conn_listener;
  assign tbl.set_listen = cmd_valid && cmd_ready && cmd_msg.command == `SMBX_CMD_LISTEN &&
    tbl.look_used && tbl.look_tcp; // R20

  // incoming connection on a listener
  always_comb
  begin
    nb_take = 1'b0;
    acc_take = 1'b0;
    if (conn_req && tbl.child_ok)
    begin
      if (state == SMBX_WAIT_CONN && conn_listener == 6'(req.ext[0]))
        acc_take = 1'b1; // R15
      else if (state != SMBX_WAIT_CONN && !cmd_valid)
        nb_take = 1'b1;
    end
  end
  assign tbl.child = acc_take || nb_take;
  assign tbl.child_port = acc_take ? listen_port : tbl.look_port; // R09
  assign conn_taken = tbl.child && tbl.child_ok;

  // listener port for child sockets
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      listen_port <= 16'h0000;
    else if (cmd_valid && cmd_ready && cmd_msg.command == `SMBX_CMD_ACCEPT)
      listen_port <= tbl.look_port; // R16
  end

  // status area report for connections taken while no accept is pending
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      nb_conn_event <= 1'b0;
      nb_conn_desc <= '0;
    end
    else
    begin
      nb_conn_event <= nb_take; // R12
      nb_conn_desc <= tbl.child_desc;
    end
  end

  // sequencer
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state <= SMBX_IDLE;
    else
      case (state)
        SMBX_IDLE:
        begin
          if (cmd_valid && cmd_ready)
          begin
            if (cmd_msg.command == `SMBX_CMD_ACCEPT && tbl.look_used && tbl.look_blocking &&
              tbl.look_listening)
              state <= SMBX_WAIT_CONN; // R14
            else
              state <= SMBX_REPLY;
          end
        end
        SMBX_WAIT_CONN:
        begin
          if (acc_take)
            state <= SMBX_REPLY; // R15
        end
        SMBX_REPLY:
        begin
          if (rsp_ready)
            state <= SMBX_IDLE;
        end
        default:
          state <= SMBX_IDLE;
      endcase
  end

  // request copy
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      req <= '0;
    else if (cmd_valid && cmd_ready)
      req <= cmd_msg;
  end

  // reply build
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      rsp_msg <= '0;
    else if (cmd_valid && cmd_ready)
    begin
      rsp_msg <= '0;
      rsp_msg.msg_id <= cmd_msg.msg_id;
      rsp_msg.msg_info <= `SMBX_MSGINFO_RSP; // R07
      rsp_msg.command <= cmd_msg.command;
      rsp_msg.frame_count <= `SMBX_FRAME_ONE;
      rsp_msg.frame_number <= `SMBX_FRAME_ONE;
      case (cmd_msg.command)
        `SMBX_CMD_CREATE_NB, `SMBX_CMD_CREATE_B:
        begin
          rsp_msg.data_size <= `SMBX_SIZE_CREATE; // R07
          if (cmd_msg.data[0] != `SMBX_TYPE_TCP && cmd_msg.data[0] != `SMBX_TYPE_UDP)
            rsp_msg.ext[7] <= `SMBX_FAULT_BAD_TYPE;
          else if (tbl.alloc_fault_busy)
            rsp_msg.ext[7] <= `SMBX_FAULT_PORT_BUSY;
          else if (!tbl.alloc_ok)
            rsp_msg.ext[7] <= `SMBX_FAULT_NO_ROOM; // R18 R19
          rsp_msg.data[0] <= 16'(tbl.alloc_desc); // R04
          rsp_msg.data[1] <= tbl.alloc_bound; // R04
        end
        `SMBX_CMD_LISTEN:
        begin
          rsp_msg.data_size <= `SMBX_SIZE_NONE;
          rsp_msg.ext[0] <= cmd_msg.ext[0];
          if (!tbl.look_used)
            rsp_msg.ext[7] <= `SMBX_FAULT_BAD_SOCKET; // R20
          else if (!tbl.look_tcp)
            rsp_msg.ext[7] <= `SMBX_FAULT_NOT_TCP; // R20
        end
        default:
        begin
          rsp_msg.data_size <= `SMBX_SIZE_ACCEPT;
          rsp_msg.ext[0] <= cmd_msg.ext[0];
          if (!tbl.look_used)
            rsp_msg.ext[7] <= `SMBX_FAULT_BAD_SOCKET;
          else if (!tbl.look_blocking || !tbl.look_listening)
            rsp_msg.ext[7] <= `SMBX_FAULT_NOT_LISTEN; // R13
        end
      endcase
    end
    else if (acc_take)
    begin
      rsp_msg.ext[1] <= listen_port; // R16
      rsp_msg.ext[2] <= conn_remote_port; // R16
      rsp_msg.ext[3] <= conn_remote_ip[31:16];
      rsp_msg.ext[4] <= conn_remote_ip[15:0];
      rsp_msg.data[0] <= 16'(tbl.child_desc); // R14
    end
  end
endmodule : smbx_cmd

`default_nettype wire

//--- test/smbx_cmd_asserts.sv
/*
  concurrent checks on the command interpreter ports.
  assumes one clock domain, bound into smbx_cmd.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smbx_defs.svh"

module smbx_cmd_asserts
  import smbx_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // command and reply
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire smbx_pkg::smbx_msg_t cmd_msg,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire smbx_pkg::smbx_msg_t rsp_msg,
  // connection events
  input wire logic conn_req,
  input wire smbx_pkg::smbx_desc_t conn_listener,
  input wire smbx_pkg::smbx_word_t conn_remote_port,
  input wire logic [31:0] conn_remote_ip,
  input wire logic conn_taken
);
  logic take;
  logic acc_wait;
  smbx_desc_t acc_lis;
  assign take = cmd_valid && cmd_ready;

  // accept pending tracker
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_wait <= 1'b0;
    else if (take && cmd_msg.command == `SMBX_CMD_ACCEPT)
      acc_wait <= 1'b1;
    else if (rsp_valid)
      acc_wait <= 1'b0;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      acc_lis <= '0;
    else if (take)
      acc_lis <= cmd_msg.ext[0][5:0];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_create;
    take && cmd_msg.command inside {`SMBX_CMD_CREATE_NB, `SMBX_CMD_CREATE_B};
  endsequence
  sequence s_accept_done;
    $rose(rsp_valid) && rsp_msg.command == `SMBX_CMD_ACCEPT && rsp_msg.ext[7] == 16'h0000;
  endsequence

  a_create_reply: assert property (s_create |=> rsp_valid
    && rsp_msg.msg_info == `SMBX_MSGINFO_RSP && rsp_msg.command == $past(cmd_msg.command)
    && rsp_msg.data_size == `SMBX_SIZE_CREATE) else $error("create reply header wrong");
  a_create_port: assert property (s_create ##0 cmd_msg.data[1] != 16'h0000 |=>
    rsp_msg.ext[7] != 16'h0000 || rsp_msg.data[1] == $past(cmd_msg.data[1]))
    else $error("bound port differs");
  a_auto_port: assert property (s_create ##0 cmd_msg.data[1] == 16'h0000 |=>
    rsp_msg.ext[7] != 16'h0000 || rsp_msg.data[1] != 16'h0000) else $error("no port chosen");
  a_listen_reply: assert property (take && cmd_msg.command == `SMBX_CMD_LISTEN |=>
    rsp_valid && rsp_msg.command == `SMBX_CMD_LISTEN && rsp_msg.data_size == `SMBX_SIZE_NONE
    && rsp_msg.ext[0] == $past(cmd_msg.ext[0])) else $error("listen reply wrong");
  a_accept_cause: assert property (s_accept_done |-> $past(conn_taken))
    else $error("accept answered without connection");
  a_accept_fields: assert property (s_accept_done |-> rsp_msg.ext[0] == {10'h000,
    $past(conn_listener)} && rsp_msg.ext[2] == $past(conn_remote_port)
    && {rsp_msg.ext[3], rsp_msg.ext[4]} == $past(conn_remote_ip)
    && rsp_msg.data[0] != rsp_msg.ext[0]) else $error("accept reply fields wrong");
  a_accept_answer: assert property (acc_wait && conn_taken && conn_listener == acc_lis
    |=> rsp_valid && rsp_msg.command == `SMBX_CMD_ACCEPT) else $error("accept not answered");
  a_reply_stands: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_msg))
    else $error("reply dropped before taken");
  a_busy_refuse: assert property (rsp_valid || acc_wait |-> !cmd_ready)
    else $error("command taken while busy");
  a_taken_cause: assert property (conn_taken |-> conn_req)
    else $error("connection taken without request");
endmodule : smbx_cmd_asserts

bind smbx_cmd smbx_cmd_asserts u_smbx_cmd_asserts (.sys_clk(sys_clk), .arst_n(arst_n),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_msg(cmd_msg), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp_msg(rsp_msg), .conn_req(conn_req),
  .conn_listener(conn_listener), .conn_remote_port(conn_remote_port),
  .conn_remote_ip(conn_remote_ip), .conn_taken(conn_taken));

`default_nettype wire

//--- test/smbx_host_model.sv
/*
  host side of the mailbox: builds commands, takes replies with stalls.
  assumes the smbx_cmd handshake on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smbx_defs.svh"

module smbx_host_model
  import smbx_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // command side
  output logic cmd_valid,
  input wire logic cmd_ready,
  output smbx_pkg::smbx_msg_t cmd_msg,
  // reply side
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire smbx_pkg::smbx_msg_t rsp_msg
);
  initial
  begin
    cmd_valid = 1'b0;
    rsp_ready = 1'b0;
    cmd_msg = '0;
  end

  // offer one command, give up after lim cycles
  task automatic put(input smbx_word_t code, d0, d1, e0, input int lim, output logic ok);
    smbx_msg_t m;
    m = '0;
    m.msg_id = smbx_word_t'($urandom);
    m.msg_info = `SMBX_MSGINFO_CMD;
    m.command = code;
    m.data_size = (code < `SMBX_CMD_LISTEN) ? `SMBX_SIZE_CREATE : `SMBX_SIZE_NONE;
    m.frame_count = `SMBX_FRAME_ONE;
    m.frame_number = `SMBX_FRAME_ONE;
    m.data[0] = d0;
    m.data[1] = d1;
    m.ext[0] = e0;
    ok = 1'b0;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_msg <= m;
    repeat (lim)
    begin
      @(negedge sys_clk);
      ok = cmd_ready;
      @(posedge sys_clk);
      if (ok)
        break;
    end
    cmd_valid <= 1'b0;
    cmd_msg <= ~m;
  endtask : put

  // wait for a reply and take it after a random stall
  task automatic get(output smbx_msg_t r, output logic got);
    got = 1'b0;
    repeat (100)
    begin
      @(negedge sys_clk);
      got = rsp_valid;
      if (got)
        break;
    end
    if (got)
    begin
      repeat ($urandom_range(2)) @(posedge sys_clk);
      @(posedge sys_clk);
      rsp_ready <= 1'b1;
      @(negedge sys_clk);
      r = rsp_msg;
      @(posedge sys_clk);
      rsp_ready <= 1'b0;
    end
  endtask : get
endmodule : smbx_host_model

`default_nettype wire

//--- test/socket_mailbox_commands_tb.sv
/*
  self-checking bench for the socket mailbox command interpreter.
  assumes the host model and checker are compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "smbx_defs.svh"

module socket_mailbox_commands_tb;
  import smbx_pkg::*;
  logic sys_clk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_ready;
  logic conn_req, conn_taken, nb_conn_event, ok, got;
  smbx_msg_t cmd_msg, rsp_msg, r;
  smbx_desc_t conn_listener, nb_conn_desc;
  smbx_word_t conn_remote_port, p, ep, d_tcp, d_udp, d_lis, kid;
  logic [31:0] conn_remote_ip, eip;
  int fail_count, checks;

  smbx_cmd u_smbx_cmd (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_msg(cmd_msg), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_msg(rsp_msg), .conn_req(conn_req), .conn_listener(conn_listener),
    .conn_remote_port(conn_remote_port), .conn_remote_ip(conn_remote_ip),
    .conn_taken(conn_taken), .nb_conn_event(nb_conn_event), .nb_conn_desc(nb_conn_desc));
  smbx_host_model u_smbx_host_model (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_msg(cmd_msg), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_msg(rsp_msg));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input smbx_word_t got_v, exp_v);
    checks++;
    if (got_v !== exp_v)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  function automatic smbx_word_t exp_size(input smbx_word_t code);
    if (code == `SMBX_CMD_ACCEPT)
      return `SMBX_SIZE_ACCEPT;
    return (code == `SMBX_CMD_LISTEN) ? `SMBX_SIZE_NONE : `SMBX_SIZE_CREATE;
  endfunction : exp_size

  // one command with reply header and fault word checked
  task automatic run(input smbx_word_t code, d0, d1, e0, flt);
    u_smbx_host_model.put(code, d0, d1, e0, 50, ok);
    chk(ok, 1);
    u_smbx_host_model.get(r, got);
    chk(got, 1);
    chk(r.msg_info, `SMBX_MSGINFO_RSP);
    chk(r.command, code);
    chk(r.data_size, exp_size(code));
    chk(r.ext[7], flt);
  endtask : run

  // network side offers a connection on a listener
  task automatic connect(input smbx_word_t lis);
    @(posedge sys_clk);
    ep = smbx_word_t'($urandom);
    eip = $urandom;
    conn_req <= 1'b1;
    conn_listener <= lis[5:0];
    conn_remote_port <= ep;
    conn_remote_ip <= eip;
    got = 1'b0;
    repeat (20)
    begin
      @(negedge sys_clk);
      got = conn_taken;
      @(posedge sys_clk);
      if (got)
        break;
    end
    chk(got, 1);
    conn_req <= 1'b0;
    conn_remote_port <= ~ep;
    conn_remote_ip <= ~eip;
  endtask : connect

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    p = smbx_word_t'($urandom(32'h5d58));
    arst_n = 1'b0;
    conn_req = 1'b0;
    conn_listener = '0;
    conn_remote_port = '0;
    conn_remote_ip = '0;
    fail_count = 0;
    checks = 0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    p = 16'h1000 + smbx_word_t'($urandom_range(16'h0fff));
    run(`SMBX_CMD_CREATE_NB, `SMBX_TYPE_TCP, p, 0, `SMBX_FAULT_NONE);
    chk(r.data[1], p);
    d_tcp = r.data[0];
    run(`SMBX_CMD_CREATE_B, `SMBX_TYPE_TCP, 0, 0, `SMBX_FAULT_NONE);
    chk(r.data[1], `SMBX_EPHEMERAL_BASE);
    d_lis = r.data[0];
    run(`SMBX_CMD_CREATE_NB, `SMBX_TYPE_UDP, 0, 0, `SMBX_FAULT_NONE);
    chk(r.data[1], `SMBX_EPHEMERAL_BASE + 16'h0001);
    d_udp = r.data[0];
    chk(d_udp != d_tcp && d_udp != d_lis && d_tcp != d_lis, 1);
    run(`SMBX_CMD_CREATE_NB, 16'h0003, 0, 0, `SMBX_FAULT_BAD_TYPE);
    run(`SMBX_CMD_CREATE_B, `SMBX_TYPE_TCP, p, 0, `SMBX_FAULT_PORT_BUSY);
    run(`SMBX_CMD_LISTEN, 0, 0, d_udp, `SMBX_FAULT_NOT_TCP);
    run(`SMBX_CMD_LISTEN, 0, 0, 16'h002f, `SMBX_FAULT_BAD_SOCKET);
    run(`SMBX_CMD_ACCEPT, 0, 0, d_udp, `SMBX_FAULT_NOT_LISTEN);
    run(`SMBX_CMD_LISTEN, 0, 0, d_lis, `SMBX_FAULT_NONE);
    chk(r.ext[0], d_lis);
    u_smbx_host_model.put(16'h0120, 0, 0, 0, 8, got);
    chk(got, 0);
    kid = d_lis;
    repeat (2)
    begin
      u_smbx_host_model.put(`SMBX_CMD_ACCEPT, 0, 0, d_lis, 50, ok);
      u_smbx_host_model.put(`SMBX_CMD_CREATE_NB, `SMBX_TYPE_TCP, 0, 0, 8, got);
      chk(got, 0);
      chk(rsp_valid, 0);
      connect(d_lis);
      u_smbx_host_model.get(r, got);
      chk(r.data_size, `SMBX_SIZE_ACCEPT);
      chk(r.ext[0], d_lis);
      chk(r.ext[1], `SMBX_EPHEMERAL_BASE);
      chk(r.ext[2], ep);
      chk(r.ext[3], eip[31:16]);
      chk(r.ext[4], eip[15:0]);
      chk(r.ext[7], `SMBX_FAULT_NONE);
      chk(r.data[0] != d_lis && r.data[0] != kid && r.data[0] != d_tcp, 1);
      kid = r.data[0];
    end
    for (int i = 0; i < 15; i++)
      run(`SMBX_CMD_CREATE_NB, `SMBX_TYPE_UDP, 0, 0,
        (i < 14) ? `SMBX_FAULT_NONE : `SMBX_FAULT_NO_ROOM);
    // connection on a non-blocking listener goes to the status path
    run(`SMBX_CMD_LISTEN, 0, 0, d_tcp, `SMBX_FAULT_NONE);
    connect(d_tcp);
    @(negedge sys_clk);
    chk(nb_conn_event, 1);
    chk(rsp_valid, 0);
    chk(nb_conn_desc != d_tcp[5:0] && nb_conn_desc != kid[5:0], 1);
    @(negedge sys_clk);
    chk(nb_conn_event, 0);
    end_of_test();
  end
endmodule : socket_mailbox_commands_tb

`default_nettype wire
